// [timer_channel_unit.sv]
// Shared constants and the per-channel clock, clear and pin function logic
//--------------------
// Functional notes
// - Clear field picks none, A, B, sync
// - Clear on compare match or capture event
// - Sync clear follows other synchronized channels
// - Edge field: rising, falling or both
// - Channel two phase mode overrides clock fields
// - Internal clock counts on its falling edge
// - External clock counts the selected edges
// - Prescaler: phi, /2, /4, /8, pins A-D
// - Control bit seven reserved, writable, undefined
// - Clock control resets to zero on reset, standby
// - Pin function resets to 08 hex, standby too
// - Five channels with identical control registers
// - Function B compare: none, 0, 1, toggle
// - Channel two toggle setting drives one instead
// - Function B capture: rising, falling, both edges
// - Pin function selects compare or capture pins
// - Function A uses the same encoding
// - Compare pin reads zero until first match
// - Pin function bit three always reads one
// - Pin functions ignored in the channel's own PWM mode
//--------------------
`timescale 1ns/1ps

package timer_channel_pkg;
   localparam int NUM_CHAN = 5;
   localparam int NUM_EXT = 4;
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int DIV_W = 3;
   localparam int PHASE_CHAN = 2;
   localparam int NO_TOGGLE_CHAN = 2;
   // Clock and clear control fields
   localparam int CLR_MSB = 6;
   localparam int CLR_LSB = 5;
   localparam int EDGE_MSB = 4;
   localparam int EDGE_LSB = 3;
   localparam int PSC_MSB = 2;
   localparam int PSC_LSB = 0;
   localparam int PSC_EXT_BIT = 2;
   localparam int EDGE_BOTH_BIT = 1;
   localparam int EDGE_FALL_BIT = 0;
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_A = 2'h1;
   localparam logic [1:0] CLR_B = 2'h2;
   localparam logic [1:0] CLR_SYNC = 2'h3;
   // Pin function control fields
   localparam int FUNC_B_MSB = 6;
   localparam int FUNC_B_LSB = 4;
   localparam int FUNC_A_MSB = 2;
   localparam int FUNC_A_LSB = 0;
   localparam int FUNC_CAP_BIT = 2;
   localparam logic [2:0] FUNC_NONE = 3'h0;
   localparam logic [2:0] FUNC_CAP_RISE = 3'h4;
   localparam logic [2:0] FUNC_CAP_FALL = 3'h5;
   localparam logic [1:0] ACT_DRIVE0 = 2'h1;
   localparam logic [1:0] ACT_DRIVE1 = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   // Reset values and fixed bits
   localparam logic [7:0] CCC_RESET = 8'h00;
   localparam logic [7:0] PFC_RESET = 8'h08;
   localparam logic [7:0] PFC_FIXED_ONE = 8'h08;
   // Byte offsets
   localparam logic [7:0] OFS_CCC_BASE = 8'h00;
   localparam logic [7:0] OFS_PFC_BASE = 8'h04;
   localparam logic [7:0] OFS_CHAN_STRIDE = 8'h08;
   localparam logic [7:0] OFS_SYNC = 8'h28;
   localparam logic [7:0] OFS_MODE = 8'h2c;
   localparam logic [7:0] OFS_STATUS = 8'h30;
   localparam int MODE_PHASE_BIT = 0;
   localparam int MODE_PWM_LSB = 1;
endpackage : timer_channel_pkg

module timer_channel_unit #(
   parameter int CHAN_ID = 0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic standby_i,
   // Configuration
   input wire logic [7:0] ccc_i,
   input wire logic [7:0] pfc_i,
   input wire logic phase_mode_i,
   input wire logic pwm_mode_i,
   // Count sources
   input wire logic [3:0] tick_i,
   input wire logic [3:0] ext_rise_i,
   input wire logic [3:0] ext_fall_i,
   // Counter events and pins
   input wire logic compare_match_a_i,
   input wire logic compare_match_b_i,
   input wire logic pin_a_i,
   input wire logic pin_b_i,
   input wire logic sync_clear_i,
   // Results
   output logic own_clear_o,
   output logic count_en_o,
   output logic counter_clear_o,
   output logic capture_a_o,
   output logic capture_b_o,
   output logic pin_a_o,
   output logic pin_a_oe_o,
   output logic pin_b_o,
   output logic pin_b_oe_o
);
   logic [1:0] pin_in;
   logic [1:0] pin_prev_r;
   logic [1:0] cmp;
   logic [1:0] cap_evt;
   logic [1:0] gr_evt;
   logic [1:0] pin_out;
   logic [1:0] pin_oe;
   logic [1:0] cap_out;
   logic [2:0] func [2];
   logic [1:0] clr_sel;
   logic [1:0] edge_sel;
   logic [2:0] psc;
   logic ext_edge;
   logic count_nxt;
   logic clear_nxt;

   assign pin_in = {pin_b_i, pin_a_i};
   assign cmp = {compare_match_b_i, compare_match_a_i};
   assign func[0] = pfc_i[timer_channel_pkg::FUNC_A_MSB:timer_channel_pkg::FUNC_A_LSB];
   assign func[1] = pfc_i[timer_channel_pkg::FUNC_B_MSB:timer_channel_pkg::FUNC_B_LSB];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pin_prev_r <= 2'h0;
      else
         pin_prev_r <= pin_in;
   end

   //--------------------
   // General register A and B functions
   //--------------------
   generate
      for (genvar g = 0; g < 2; g++)
      begin : gen_gr
         logic [2:0] f;
         logic is_cap;
         logic rise;
         logic fall;
         logic out_r;
         logic oe_r;
         logic cap_r;
         // PWM owns the pins, so the settings are treated as compare, no output
         assign f = pwm_mode_i ? timer_channel_pkg::FUNC_NONE : func[g];
         assign is_cap = f[timer_channel_pkg::FUNC_CAP_BIT];
         assign rise = pin_in[g] & ~pin_prev_r[g];
         assign fall = ~pin_in[g] & pin_prev_r[g];
         assign cap_evt[g] = is_cap & ((f == timer_channel_pkg::FUNC_CAP_RISE) ? rise :
                             (f == timer_channel_pkg::FUNC_CAP_FALL) ? fall : (rise | fall));
         assign gr_evt[g] = is_cap ? cap_evt[g] : cmp[g];
         always_ff @(posedge clk_i)
         begin
            if (rst_i || standby_i)
               out_r <= 1'b0;
            else if (!is_cap && cmp[g])
            begin
               case (f[1:0])
                  timer_channel_pkg::ACT_DRIVE0: out_r <= 1'b0;
                  timer_channel_pkg::ACT_DRIVE1: out_r <= 1'b1;
                  timer_channel_pkg::ACT_TOGGLE: out_r <= (CHAN_ID == timer_channel_pkg::NO_TOGGLE_CHAN) ? 1'b1 : ~out_r;
                  default: out_r <= out_r;
               endcase
            end
         end
         always_ff @(posedge clk_i)
         begin
            if (rst_i || standby_i)
            begin
               oe_r <= 1'b0;
               cap_r <= 1'b0;
            end
            else
            begin
               oe_r <= !is_cap && (f != timer_channel_pkg::FUNC_NONE);
               cap_r <= cap_evt[g];
            end
         end
         assign pin_out[g] = out_r;
         assign pin_oe[g] = oe_r;
         assign cap_out[g] = cap_r;
      end
   endgenerate

   //--------------------
   // Count clock and clear source
   //--------------------
   assign clr_sel = ccc_i[timer_channel_pkg::CLR_MSB:timer_channel_pkg::CLR_LSB];
   assign edge_sel = ccc_i[timer_channel_pkg::EDGE_MSB:timer_channel_pkg::EDGE_LSB];
   assign psc = ccc_i[timer_channel_pkg::PSC_MSB:timer_channel_pkg::PSC_LSB];
   assign ext_edge = edge_sel[timer_channel_pkg::EDGE_BOTH_BIT] ? (ext_rise_i[psc[1:0]] | ext_fall_i[psc[1:0]]) :
                     edge_sel[timer_channel_pkg::EDGE_FALL_BIT] ? ext_fall_i[psc[1:0]] : ext_rise_i[psc[1:0]];
   always_comb
   begin
      if (phase_mode_i && CHAN_ID == timer_channel_pkg::PHASE_CHAN)
         count_nxt = |(ext_rise_i[1:0] | ext_fall_i[1:0]);
      else if (psc[timer_channel_pkg::PSC_EXT_BIT])
         count_nxt = ext_edge;
      else
         count_nxt = tick_i[psc[1:0]];
   end
   assign own_clear_o = ((clr_sel == timer_channel_pkg::CLR_A) & gr_evt[0]) |
                        ((clr_sel == timer_channel_pkg::CLR_B) & gr_evt[1]);
   assign clear_nxt = own_clear_o | ((clr_sel == timer_channel_pkg::CLR_SYNC) & sync_clear_i);

   always_ff @(posedge clk_i)
   begin
      if (rst_i || standby_i)
      begin
         count_en_o <= 1'b0;
         counter_clear_o <= 1'b0;
      end
      else
      begin
         count_en_o <= count_nxt;
         counter_clear_o <= clear_nxt;
      end
   end

   assign capture_a_o = cap_out[0];
   assign capture_b_o = cap_out[1];
   assign pin_a_o = pin_out[0];
   assign pin_b_o = pin_out[1];
   assign pin_a_oe_o = pin_oe[0];
   assign pin_b_oe_o = pin_oe[1];
endmodule : timer_channel_unit

// [timer_channel_control.sv]
// Five-channel timer clock, clear and pin function control with Wishbone slave
`timescale 1ns/1ps

module timer_channel_control #(
   parameter int NUM_CHAN = timer_channel_pkg::NUM_CHAN
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic standby_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [timer_channel_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [timer_channel_pkg::DAT_W-1:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic wb_ack_o,
   output logic [timer_channel_pkg::DAT_W-1:0] wb_dat_o,
   // External clock pins
   input wire logic ext_clock_pin_a_i,
   input wire logic ext_clock_pin_b_i,
   input wire logic ext_clock_pin_c_i,
   input wire logic ext_clock_pin_d_i,
   // Counter events from the channel counters
   input wire logic [NUM_CHAN-1:0] compare_match_a_i,
   input wire logic [NUM_CHAN-1:0] compare_match_b_i,
   // Compare and capture pins
   input wire logic [NUM_CHAN-1:0] compare_capture_pin_a_i,
   input wire logic [NUM_CHAN-1:0] compare_capture_pin_b_i,
   output logic [NUM_CHAN-1:0] compare_capture_pin_a_o,
   output logic [NUM_CHAN-1:0] compare_capture_pin_a_oe_o,
   output logic [NUM_CHAN-1:0] compare_capture_pin_b_o,
   output logic [NUM_CHAN-1:0] compare_capture_pin_b_oe_o,
   // Counter controls
   output logic [NUM_CHAN-1:0] count_en_o,
   output logic [NUM_CHAN-1:0] counter_clear_o,
   output logic [NUM_CHAN-1:0] capture_a_o,
   output logic [NUM_CHAN-1:0] capture_b_o
);
   //--------------------
   // Registers
   //--------------------
   logic [7:0] timer_clock_clear_control_r [NUM_CHAN];
   logic [7:0] timer_pin_function_control_r [NUM_CHAN];
   logic [NUM_CHAN-1:0] channel_sync_register_r;
   logic phase_count_mode_flag_r;
   logic [NUM_CHAN-1:0] pwm_mode_r;
   logic ack_r;
   logic [timer_channel_pkg::DAT_W-1:0] dat_r;
   logic [timer_channel_pkg::DIV_W-1:0] div_cnt_r;
   logic [3:0] ext_prev_r;

   //--------------------
   // Bus decode
   //--------------------
   logic req;
   logic wr_lo;
   logic [7:0] word_adr;
   logic [NUM_CHAN-1:0] hit_ccc;
   logic [NUM_CHAN-1:0] hit_pfc;
   logic hit_sync;
   logic hit_mode;
   logic hit_status;
   logic [timer_channel_pkg::DAT_W-1:0] rd_nxt;

   // A fresh request only; the cycle after ack the master may still hold stb
   assign req = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr_lo = req && wb_we_i && wb_sel_i[0];
   assign word_adr = {wb_adr_i[7:2], 2'b00};
   assign hit_sync = (word_adr == timer_channel_pkg::OFS_SYNC);
   assign hit_mode = (word_adr == timer_channel_pkg::OFS_MODE);
   assign hit_status = (word_adr == timer_channel_pkg::OFS_STATUS);

   generate
      for (genvar n = 0; n < NUM_CHAN; n++)
      begin : gen_dec
         localparam logic [7:0] CH_OFS = 8'(n * timer_channel_pkg::OFS_CHAN_STRIDE);
         assign hit_ccc[n] = (word_adr == 8'(timer_channel_pkg::OFS_CCC_BASE + CH_OFS));
         assign hit_pfc[n] = (word_adr == 8'(timer_channel_pkg::OFS_PFC_BASE + CH_OFS));
      end
   endgenerate

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_r <= 1'b0;
      else
         ack_r <= req;
   end

   //--------------------
   // Read data
   //--------------------
   always_comb
   begin
      rd_nxt = '0;
      for (int n = 0; n < NUM_CHAN; n++)
      begin
         if (hit_ccc[n])
            rd_nxt[7:0] = timer_clock_clear_control_r[n];
         if (hit_pfc[n])
            rd_nxt[7:0] = timer_pin_function_control_r[n] | timer_channel_pkg::PFC_FIXED_ONE;
      end
      if (hit_sync)
         rd_nxt[NUM_CHAN-1:0] = channel_sync_register_r;
      if (hit_mode)
      begin
         rd_nxt[timer_channel_pkg::MODE_PHASE_BIT] = phase_count_mode_flag_r;
         rd_nxt[timer_channel_pkg::MODE_PWM_LSB +: NUM_CHAN] = pwm_mode_r;
      end
      if (hit_status)
      begin
         rd_nxt[NUM_CHAN-1:0] = compare_capture_pin_a_o;
         rd_nxt[NUM_CHAN +: NUM_CHAN] = compare_capture_pin_b_o;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_r <= '0;
      else if (req && !wb_we_i)
         dat_r <= rd_nxt;
   end

   //--------------------
   // Per-channel control registers
   //--------------------
   generate
      for (genvar n = 0; n < NUM_CHAN; n++)
      begin : gen_regs
         always_ff @(posedge clk_i)
         begin
            if (rst_i || standby_i)
            begin
               timer_clock_clear_control_r[n] <= timer_channel_pkg::CCC_RESET;
               timer_pin_function_control_r[n] <= timer_channel_pkg::PFC_RESET;
            end
            else if (wr_lo)
            begin
               // Bit seven is kept as written, so it reads back what software left there
               if (hit_ccc[n])
                  timer_clock_clear_control_r[n] <= wb_dat_i[7:0];
               if (hit_pfc[n])
                  timer_pin_function_control_r[n] <= wb_dat_i[7:0] | timer_channel_pkg::PFC_FIXED_ONE;
            end
         end
      end
   endgenerate

   //--------------------
   // Shared sync and mode registers
   //--------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i || standby_i)
         channel_sync_register_r <= '0;
      else if (wr_lo && hit_sync)
         channel_sync_register_r <= wb_dat_i[NUM_CHAN-1:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || standby_i)
      begin
         phase_count_mode_flag_r <= 1'b0;
         pwm_mode_r <= '0;
      end
      else if (wr_lo && hit_mode)
      begin
         phase_count_mode_flag_r <= wb_dat_i[timer_channel_pkg::MODE_PHASE_BIT];
         pwm_mode_r <= wb_dat_i[timer_channel_pkg::MODE_PWM_LSB +: NUM_CHAN];
      end
   end

   //--------------------
   // Prescaler and external edge detection
   //--------------------
   logic [3:0] tick;
   logic [3:0] ext_pins;
   logic [3:0] ext_rise;
   logic [3:0] ext_fall;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         div_cnt_r <= '0;
      else
         div_cnt_r <= div_cnt_r + 3'h1;
   end

   // Each tick marks the falling edge of the divided clock
   assign tick = {&div_cnt_r[2:0], &div_cnt_r[1:0], div_cnt_r[0], 1'b1};
   assign ext_pins = {ext_clock_pin_d_i, ext_clock_pin_c_i, ext_clock_pin_b_i, ext_clock_pin_a_i};

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ext_prev_r <= '0;
      else
         ext_prev_r <= ext_pins;
   end

   assign ext_rise = ext_pins & ~ext_prev_r;
   assign ext_fall = ~ext_pins & ext_prev_r;

   //--------------------
   // Channels
   //--------------------
   logic [NUM_CHAN-1:0] own_clear;
   logic [NUM_CHAN-1:0] sync_clear;

   generate
      for (genvar n = 0; n < NUM_CHAN; n++)
      begin : gen_chan
         localparam logic [NUM_CHAN-1:0] SELF = NUM_CHAN'(1 << n);
         // Only synchronized channels take part, and a channel never clears itself by sync
         assign sync_clear[n] = channel_sync_register_r[n] &
                                |(own_clear & channel_sync_register_r & ~SELF);
         timer_channel_unit #(
            .CHAN_ID(n)
         ) u_chan (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .standby_i(standby_i),
            .ccc_i(timer_clock_clear_control_r[n]),
            .pfc_i(timer_pin_function_control_r[n]),
            .phase_mode_i(phase_count_mode_flag_r),
            .pwm_mode_i(pwm_mode_r[n]),
            .tick_i(tick),
            .ext_rise_i(ext_rise),
            .ext_fall_i(ext_fall),
            .compare_match_a_i(compare_match_a_i[n]),
            .compare_match_b_i(compare_match_b_i[n]),
            .pin_a_i(compare_capture_pin_a_i[n]),
            .pin_b_i(compare_capture_pin_b_i[n]),
            .sync_clear_i(sync_clear[n]),
            .own_clear_o(own_clear[n]),
            .count_en_o(count_en_o[n]),
            .counter_clear_o(counter_clear_o[n]),
            .capture_a_o(capture_a_o[n]),
            .capture_b_o(capture_b_o[n]),
            .pin_a_o(compare_capture_pin_a_o[n]),
            .pin_a_oe_o(compare_capture_pin_a_oe_o[n]),
            .pin_b_o(compare_capture_pin_b_o[n]),
            .pin_b_oe_o(compare_capture_pin_b_oe_o[n])
         );
      end
   endgenerate

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
endmodule : timer_channel_control

// [tcc_props.sv]
// Concurrent checks on the timer channel control block ports
`timescale 1ns/1ps
module tcc_props #(
   parameter int NUM_CHAN = 5
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic standby_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic [timer_channel_pkg::DAT_W-1:0] wb_dat_o,
   // Channel signals
   input wire logic [NUM_CHAN-1:0] compare_match_a_i,
   input wire logic [NUM_CHAN-1:0] compare_capture_pin_a_i,
   input wire logic [NUM_CHAN-1:0] compare_capture_pin_a_o,
   input wire logic [NUM_CHAN-1:0] compare_capture_pin_a_oe_o,
   input wire logic [NUM_CHAN-1:0] count_en_o,
   input wire logic [NUM_CHAN-1:0] capture_a_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   //--------------------
   // Bus
   //--------------------
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held over one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   rdata_hold_a: assert property ($changed(wb_dat_o) |-> (wb_ack_o && !wb_we_i) || $past(rst_i))
      else $error("read data moved outside a read");
   // Reset must win even while the default disable is active
   reset_quiet_a: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i |=> !wb_ack_o && wb_dat_o == '0 && count_en_o == '0 && compare_capture_pin_a_oe_o == '0)
      else $error("outputs active after reset");
   //--------------------
   // Channels
   //--------------------
   standby_quiet_a: assert property (standby_i |=> compare_capture_pin_a_o == '0 && capture_a_o == '0)
      else $error("outputs active after standby");
   capture_cause_a: assert property (|capture_a_o |->
      (capture_a_o & ~($past(compare_capture_pin_a_i) ^ $past(compare_capture_pin_a_i, 2))) == '0)
      else $error("capture without pin change");
   pin_cause_a: assert property (!$past(rst_i) && !$past(standby_i) |->
      ((compare_capture_pin_a_o ^ $past(compare_capture_pin_a_o)) & ~$past(compare_match_a_i)) == '0)
      else $error("pin level moved without match");
   oe_cause_a: assert property ($changed(compare_capture_pin_a_oe_o) |->
      $past(wb_ack_o && wb_we_i) || (wb_ack_o && wb_we_i) || $past(rst_i) || $past(standby_i))
      else $error("enable moved without write");
   cover property (wb_ack_o && wb_we_i);
   cover property (|capture_a_o);
   cover property ($rose(|compare_capture_pin_a_o));
endmodule : tcc_props

bind timer_channel_control tcc_props #(.NUM_CHAN(NUM_CHAN)) props_i (.*);

// [pin_partner.sv]
// Far-side model: external clock pins and capture pin levels
`timescale 1ns/1ps
module pin_partner (
   // Clock
   input wire logic clk_i,
   // Commands
   input wire logic [3:0] run_i,
   input wire logic [4:0] lvl_a_i,
   input wire logic [4:0] lvl_b_i,
   // Pins
   output logic [3:0] ext_o = 4'h0,
   output logic [4:0] pin_a_o = 5'h00,
   output logic [4:0] pin_b_o = 5'h00
);
   logic ph_r = 1'b0;
   // Clocks stand still outside bursts; a burst lasting a multiple of four cycles ends low
   always_ff @(posedge clk_i)
   begin
      ph_r <= !ph_r;
      if (ph_r)
         ext_o <= ext_o ^ run_i;
      pin_a_o <= lvl_a_i;
      pin_b_o <= lvl_b_i;
   end
endmodule : pin_partner

// [tb_top.sv]
// Self-checking bench for the timer channel control block
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic standby_i = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'h0;
   logic [3:0] run = 4'h0;
   logic [4:0] lva = 5'h00, lvb = 5'h00, ma = 5'h00, mb = 5'h00;
   logic ack;
   logic [31:0] rdat, q;
   logic [3:0] ext;
   logic [4:0] ppa, ppb, pai, pbi, pao, paoe, pbo, pboe, cen, clr, cpa, cpb;
   int c_en [5] = '{default: 0};
   int c_clr [5] = '{default: 0};
   int c_ca [5] = '{default: 0};
   int c_cb [5] = '{default: 0};
   int n_tests = 0;
   int n_mismatch = 0;
   // Pin wire: design drives while enabled, partner otherwise
   assign pai = (paoe & pao) | (~paoe & ppa);
   assign pbi = (pboe & pbo) | (~pboe & ppb);
   timer_channel_control uut (.clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_ack_o(ack), .wb_dat_o(rdat),
      .ext_clock_pin_a_i(ext[0]), .ext_clock_pin_b_i(ext[1]), .ext_clock_pin_c_i(ext[2]), .ext_clock_pin_d_i(ext[3]),
      .compare_match_a_i(ma), .compare_match_b_i(mb), .compare_capture_pin_a_i(pai), .compare_capture_pin_b_i(pbi),
      .compare_capture_pin_a_o(pao), .compare_capture_pin_a_oe_o(paoe), .compare_capture_pin_b_o(pbo),
      .compare_capture_pin_b_oe_o(pboe), .count_en_o(cen), .counter_clear_o(clr), .capture_a_o(cpa), .capture_b_o(cpb));
   pin_partner far_i (.clk_i(clk_i), .run_i(run), .lvl_a_i(lva), .lvl_b_i(lvb), .ext_o(ext), .pin_a_o(ppa), .pin_b_o(ppb));
   initial
   begin
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      for (int i = 0; i < 5; i++)
      begin
         c_en[i] <= c_en[i] + int'(cen[i]);
         c_clr[i] <= c_clr[i] + int'(clr[i]);
         c_ca[i] <= c_ca[i] + int'(cpa[i]);
         c_cb[i] <= c_cb[i] + int'(cpb[i]);
      end
   end
   //--------------------
   // Shared tasks
   //--------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
   endtask : w
   task automatic wb(input logic wr_en, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= wr_en;
      adr <= a;
      wdat <= {24'h000000, d};
      sel <= s;
      @(posedge clk_i);
      while (ack !== 1'b1)
         @(posedge clk_i);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d, 4'h1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 8'h00, 4'h1);
      chk(q, exp);
   endtask : rd
   task automatic pm(input logic [4:0] a, input logic [4:0] b);
      ma <= a;
      mb <= b;
      @(posedge clk_i);
      ma <= 5'h00;
      mb <= 5'h00;
      @(posedge clk_i);
   endtask : pm
   function automatic logic [7:0] ac(input int n);
      return timer_channel_pkg::OFS_CCC_BASE + 8'(n) * timer_channel_pkg::OFS_CHAN_STRIDE;
   endfunction : ac
   function automatic logic [7:0] ap(input int n);
      return timer_channel_pkg::OFS_PFC_BASE + 8'(n) * timer_channel_pkg::OFS_CHAN_STRIDE;
   endfunction : ap
   //--------------------
   // Scenarios
   //--------------------
   task automatic t_regs();
      for (int n = 0; n < 5; n++)
      begin
         rd(ac(n), 32'(timer_channel_pkg::CCC_RESET));
         rd(ap(n), 32'(timer_channel_pkg::PFC_RESET));
      end
      chk(32'({pao, paoe, pbo, pboe}), 32'h0);
      wr(ac(3), 8'hff);
      rd(ac(3), 32'hff);
      wr(ap(3), 8'h00);
      rd(ap(3), 32'h08);
      wr(ap(3), 8'hf7);
      rd(ap(3), 32'hff);
      wb(1'b1, ac(3), 8'h12, 4'h0);
      rd(ac(3), 32'hff);
      wr(8'h3c, 8'h5a);
      rd(8'h3c, 32'h0);
      wr(ac(3), 8'h00);
      wr(ap(3), 8'h08);
      $display("registers done");
   endtask : t_regs
   task automatic t_clock();
      int s;
      for (int p = 0; p < 4; p++)
      begin
         wr(ac(0), 8'(p));
         w(3);
         s = c_en[0];
         w(16);
         chk(32'(c_en[0] - s), 32'(16 >> p));
      end
      for (int p = 0; p < 4; p++)
         for (int e = 0; e < 4; e++)
         begin
            wr(ac(0), 8'h04 | 8'(p) | 8'(e << 3));
            w(3);
            s = c_en[0];
            run <= 4'(1 << p);
            w(12);
            run <= 4'h0;
            w(6);
            chk(32'(c_en[0] - s), (e > 1) ? 32'h6 : 32'h3);
         end
      wr(timer_channel_pkg::OFS_MODE, 8'h01);
      rd(timer_channel_pkg::OFS_MODE, 32'h1);
      wr(ac(2), 8'h00);
      w(3);
      s = c_en[2];
      run <= 4'h1;
      w(12);
      run <= 4'h0;
      w(6);
      chk(32'(c_en[2] - s), 32'h6);
      wr(timer_channel_pkg::OFS_MODE, 8'h00);
      $display("clock select done");
   endtask : t_clock
   task automatic t_cmp();
      int c;
      logic [15:0] tab [6] = '{16'h0221, 16'h0110, 16'h0331, 16'h0330, 16'h2331, 16'h2331};
      for (int i = 0; i < 6; i++)
      begin
         c = int'(tab[i][15:12]);
         wr(ap(c), tab[i][11:4]);
         pm(5'(1 << c), 5'(1 << c));
         chk(32'({pao[c], pbo[c], paoe[c], pboe[c]}), 32'({{2{tab[i][0]}}, 2'h3}));
      end
      rd(timer_channel_pkg::OFS_STATUS, 32'h84);
      wr(ap(0), 8'h08);
      w(2);
      chk(32'({paoe[0], pboe[0]}), 32'h0);
      wr(timer_channel_pkg::OFS_MODE, 8'h02);
      wr(ap(0), 8'h22);
      w(2);
      pm(5'h01, 5'h01);
      chk(32'({pao[0], pbo[0], paoe[0], pboe[0]}), 32'h0);
      wr(timer_channel_pkg::OFS_MODE, 8'h00);
      $display("compare output done");
   endtask : t_cmp
   task automatic t_cap();
      int sa, sb, sc;
      logic [15:0] tab [4] = '{16'h4c11, 16'h5d01, 16'h6e12, 16'h7f12};
      wr(ac(1), 8'h40);
      for (int i = 0; i < 4; i++)
      begin
         wr(ap(1), tab[i][15:8]);
         w(2);
         sa = c_ca[1];
         sb = c_cb[1];
         sc = c_clr[1];
         lva <= 5'h02;
         lvb <= 5'h02;
         w(4);
         chk(32'({8'(c_ca[1] - sa), 8'(c_cb[1] - sb)}), 32'({2{4'h0, tab[i][7:4]}}));
         lva <= 5'h00;
         lvb <= 5'h00;
         w(4);
         chk(32'({8'(c_ca[1] - sa), 8'(c_cb[1] - sb)}), 32'({2{4'h0, tab[i][3:0]}}));
         chk(32'(c_clr[1] - sc), 32'(tab[i][3:0]));
      end
      wr(ap(1), 8'h08);
      wr(ac(1), 8'h00);
      $display("capture done");
   endtask : t_cap
   task automatic t_clr();
      int s;
      logic [7:0] v [3] = '{8'h00, 8'h20, 8'h40};
      for (int i = 0; i < 3; i++)
      begin
         wr(ac(0), v[i]);
         s = c_clr[0];
         pm(5'h01, 5'h00);
         w(2);
         chk(32'(c_clr[0] - s), 32'(v[i] == 8'h20));
         s = c_clr[0];
         pm(5'h00, 5'h01);
         w(2);
         chk(32'(c_clr[0] - s), 32'(v[i] == 8'h40));
      end
      wr(timer_channel_pkg::OFS_SYNC, 8'h03);
      rd(timer_channel_pkg::OFS_SYNC, 32'h3);
      wr(ac(1), 8'h60);
      wr(ac(0), 8'h20);
      s = c_clr[1];
      pm(5'h01, 5'h00);
      w(2);
      chk(32'(c_clr[1] - s), 32'h1);
      wr(timer_channel_pkg::OFS_SYNC, 8'h00);
      wr(ac(1), 8'h00);
      wr(ac(4), 8'h9f);
      wr(ap(4), 8'h77);
      standby_i <= 1'b1;
      w(2);
      standby_i <= 1'b0;
      w(1);
      rd(ac(4), 32'h00);
      rd(ap(4), 32'h08);
      $display("clear and standby done");
   endtask : t_clr
   task automatic summarize();
      $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize
   initial
   begin
      #100000;
      n_mismatch++;
      $display("watchdog expired");
      summarize();
   end
   initial
   begin
      w(3);
      rst_i <= 1'b0;
      w(1);
      t_regs();
      t_clock();
      t_cmp();
      t_cap();
      t_clr();
      summarize();
   end
endmodule : tb_top
